/* design/tcpi_map.vh */
// Constants for the control packet interpreter
`ifndef TCPI_MAP_VH
`define TCPI_MAP_VH
`define TCPI_SYNC 8'h0D
`define TCPI_ST_ID 8'h08
`define TCPI_ST_LF 8'h0A
`define TCPI_DIR_ID 8'h09
`define TCPI_VER_REQ 8'h12
`define TCPI_VER_ARG 8'h00
`define TCPI_VER_ID 8'hFF
`define TCPI_OP_TUNING_FREQUENCY_WORD 8'hB0
`define TCPI_OP_ATT 8'hB4
`define TCPI_OP_DIR 8'hB2
`define TCPI_TUNING_FREQUENCY_WORD_LO 16'h01F4
`define TCPI_TUNING_FREQUENCY_WORD_HI 16'h7530
`define TCPI_POS_MAX 8'hE7
`define TCPI_SHORT_MA 8'hC8
`define TCPI_ZERO8 8'h00
`define TCPI_ONE8 8'h01
`define TCPI_ONE4 4'h1
`define TCPI_ZERO4 4'h0
`define TCPI_ZERO16 16'h0000
`define TCPI_IDX_CUR 4'h2
`define TCPI_LEN_ST 4'h8
`define TCPI_LEN_DIR 4'hB
`define TCPI_LEN_VER 4'h3
`define TCPI_IDX_SYNC2 4'h3
`define TCPI_IDX_LF 4'h4
`define TCPI_IDX_FLO 4'h5
`define TCPI_IDX_FHI 4'h6
`define TCPI_IDX_ATT 4'h7
`define TCPI_IDX_SYNC3 4'h8
`define TCPI_IDX_DIRID 4'h9
`define TCPI_IDX_POS 4'hA
`define TCPI_PERIOD_MS 500
`define TCPI_CLK_KHZ 250000
`define TCPI_PERIOD_CYC (`TCPI_PERIOD_MS * `TCPI_CLK_KHZ)
`endif

/* design/tcpi_buf2.v */
// Two-entry skid buffer for outgoing bytes
`default_nettype none
module tcpi_buf2
(
    input wire CLOCK, // clock
    input wire RST, // sync reset
    input wire [7:0] in_data, // byte in
    input wire in_valid, // byte offered
    output wire in_ready, // space free
    output reg [7:0] out_data, // head byte
    output wire out_valid, // head valid
    input wire out_ready // sink takes
);
    reg [7:0] spare_reg;
    reg [1:0] count_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count_reg != 2'd2);
    assign out_valid = (count_reg != 2'd0);
    always @(posedge CLOCK)
    begin
        if (RST)
        begin
            count_reg <= 2'd0;
            out_data <= 8'h00;
            spare_reg <= 8'h00;
        end
        else
        begin
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
            if (pop)
            begin
                if (count_reg == 2'd2)
                    out_data <= spare_reg;
                else if (push)
                    out_data <= in_data;
            end
            else if (push)
            begin
                if (count_reg == 2'd0)
                    out_data <= in_data;
                else
                    spare_reg <= in_data;
            end
            if (pop && push && count_reg == 2'd2)
                spare_reg <= in_data;
        end
    end
endmodule
`default_nettype wire

/* design/tcpi_interp.v */
// Control stream interpreter: command parser and status packet sender
// Functional notes
// - Status packet: eight fixed-layout bytes
// - Frequency 16-bit 1 kHz, low byte first
// - Over 200 mA short, zero open
// - Status twice per second in session
// - Local change sends status at once
// - Setting command sends feedback status
// - Only one client session at once
// - Session indicator shown while connected
// - Direction packet appended, eleven bytes
// - Position codes 0 to 231
// - Version request answered with version reply
// - Version byte: number and location bit
// - Flip firmware location after reprogramming
// - Out-of-band frequency selects full range
// - Exactly 500 kHz selects low range
// - Attenuation command, 0.5 dB units
// - Direction command on direction variant
// - Only whole commands per transmission
`default_nettype none
`include "tcpi_map.vh"
module tcpi_interp #(
    parameter DIR_VARIANT = 1,
    parameter [31:0] PERIOD_CYC = `TCPI_PERIOD_CYC
)
(
    input wire CLOCK, // 250 MHz clock
    input wire RST, // sync reset, high
    input wire CONN_REQ, // new client asks to connect
    output wire CONN_ACCEPT, // pulse: request accepted
    input wire CONN_CLOSE, // client closed session
    output reg SESSION_ACTIVE, // session open / display S
    input wire [7:0] RX_DATA, // received byte
    input wire RX_VALID, // received byte valid
    output wire RX_READY, // parser takes byte
    output wire [7:0] TX_DATA, // byte to client
    output wire TX_VALID, // byte valid
    input wire TX_READY, // stack takes byte
    input wire [7:0] CURRENT_MA, // measured current
    input wire KNOB_EVENT, // pulse: local knob change
    input wire [15:0] KNOB_TUNING_FREQUENCY_WORD, // frequency from knob
    input wire [7:0] KNOB_ATT, // attenuation from knob
    input wire [6:0] FW_VERSION, // firmware version number
    input wire REPROG_DONE, // pulse: reprogramming succeeded
    output reg [15:0] TUNING_FREQUENCY_WORD, // frequency, kHz
    output reg [7:0] ATTENUATION_CODE, // attenuation, 0.5 dB
    output reg [7:0] POSITION_CODE, // direction step
    output reg LOW_RANGE, // 0 to 0.5 MHz range selected
    output reg FW_LOCATION, // active firmware memory
    output reg SHORT_FAULT, // line short
    output reg OPEN_FAULT // line open
);
    localparam P_SYNC = 6'b000001;
    localparam P_OP = 6'b000010;
    localparam P_A1 = 6'b000100;
    localparam P_A2 = 6'b001000;
    localparam P_DONE = 6'b010000;
    localparam P_SKIP = 6'b100000;
    localparam T_IDLE = 3'b001;
    localparam T_STAT = 3'b010;
    localparam T_VER = 3'b100;

    // Argument count per opcode; unknown opcodes resync on next sync byte
    function [1:0] op_args;
        input [7:0] op;
        begin
            case (op)
                `TCPI_OP_TUNING_FREQUENCY_WORD: op_args = 2'd2;
                `TCPI_OP_ATT: op_args = 2'd1;
                `TCPI_OP_DIR: op_args = 2'd1;
                `TCPI_VER_REQ: op_args = 2'd1;
                default: op_args = 2'd0;
            endcase
        end
    endfunction

    reg [5:0] pstate_reg;
    reg [7:0] op_reg;
    reg [7:0] arg1_reg;
    reg [31:0] tick_reg;
    reg stat_pend_reg;
    reg ver_pend_reg;
    reg [2:0] tstate_reg;
    reg [3:0] idx_reg;
    reg [7:0] cur_snap_reg;
    reg [15:0] frq_snap_reg;
    reg [7:0] att_snap_reg;
    reg [7:0] pos_snap_reg;
    reg prev_short_reg;
    reg prev_open_reg;
    reg [7:0] tx_byte;
    reg [3:0] tx_len;
    wire buf_ready;
    wire tx_push = (tstate_reg != T_IDLE) && buf_ready;
    wire rx_take = RX_VALID && RX_READY;
    wire is_short = CURRENT_MA > `TCPI_SHORT_MA;
    wire is_open = CURRENT_MA == `TCPI_ZERO8;
    wire fault_edge = (is_short && !prev_short_reg) || (is_open && !prev_open_reg);
    wire period_hit = tick_reg >= PERIOD_CYC - 32'd1;
    reg cmd_apply;

    assign CONN_ACCEPT = CONN_REQ && !SESSION_ACTIVE;
    // Parser stalls during a pending version reply so no request is dropped
    // Also stalls in P_DONE and P_SKIP, else a following sync byte is lost
    assign RX_READY = SESSION_ACTIVE && (pstate_reg != P_DONE) && (pstate_reg != P_SKIP)
                      && !ver_pend_reg;

    always @(posedge CLOCK)
    begin
        if (RST)
            SESSION_ACTIVE <= 1'b0;
        else if (CONN_CLOSE)
            SESSION_ACTIVE <= 1'b0;
        else if (CONN_ACCEPT)
            SESSION_ACTIVE <= 1'b1;
    end

    // Command parser
    always @(posedge CLOCK)
    begin
        cmd_apply <= 1'b0;
        if (RST || !SESSION_ACTIVE)
        begin
            pstate_reg <= P_SYNC;
            op_reg <= `TCPI_ZERO8;
            arg1_reg <= `TCPI_ZERO8;
            cmd_apply <= 1'b0;
        end
        else
        begin
            case (pstate_reg)
                P_SYNC:
                    if (rx_take && RX_DATA == `TCPI_SYNC)
                        pstate_reg <= P_OP;
                P_OP:
                    if (rx_take)
                    begin
                        op_reg <= RX_DATA;
                        if (op_args(RX_DATA) == 2'd0)
                            pstate_reg <= P_SYNC;
                        else
                            pstate_reg <= P_A1;
                    end
                P_A1:
                    if (rx_take)
                    begin
                        arg1_reg <= RX_DATA;
                        pstate_reg <= (op_args(op_reg) == 2'd2) ? P_A2 : P_DONE;
                    end
                P_A2:
                    if (rx_take)
                    begin
                        op_reg <= op_reg;
                        pstate_reg <= P_SKIP;
                        cmd_apply <= 1'b1;
                    end
                P_DONE:
                begin
                    pstate_reg <= P_SYNC;
                    cmd_apply <= 1'b1;
                end
                P_SKIP:
                    pstate_reg <= P_SYNC;
                default:
                    pstate_reg <= P_SYNC;
            endcase
        end
    end

    // High byte of a frequency is latched alongside the apply strobe
    reg [7:0] arg2_reg;
    always @(posedge CLOCK)
    begin
        if (RST)
            arg2_reg <= `TCPI_ZERO8;
        else if (rx_take && pstate_reg == P_A2)
            arg2_reg <= RX_DATA;
    end

    wire [15:0] cmd_tuning_frequency_word = {arg2_reg, arg1_reg};
    always @(posedge CLOCK)
    begin
        if (RST)
        begin
            TUNING_FREQUENCY_WORD <= `TCPI_ZERO16;
            ATTENUATION_CODE <= `TCPI_ZERO8;
            POSITION_CODE <= `TCPI_ZERO8;
            LOW_RANGE <= 1'b0;
            ver_pend_reg <= 1'b0;
        end
        else
        begin
            // A reply pending at close is dropped with the session
            if (tstate_reg == T_VER || !SESSION_ACTIVE)
                ver_pend_reg <= 1'b0;
            if (KNOB_EVENT)
            begin
                TUNING_FREQUENCY_WORD <= KNOB_TUNING_FREQUENCY_WORD;
                ATTENUATION_CODE <= KNOB_ATT;
                LOW_RANGE <= (KNOB_TUNING_FREQUENCY_WORD == `TCPI_TUNING_FREQUENCY_WORD_LO);
            end
            if (cmd_apply)
            begin
                case (op_reg)
                    `TCPI_OP_TUNING_FREQUENCY_WORD:
                    begin
                        TUNING_FREQUENCY_WORD <= cmd_tuning_frequency_word;
                        // Below 500 or above 30000 kHz: full range
                        LOW_RANGE <= (cmd_tuning_frequency_word == `TCPI_TUNING_FREQUENCY_WORD_LO);
                    end
                    `TCPI_OP_ATT:
                        ATTENUATION_CODE <= arg1_reg;
                    `TCPI_OP_DIR:
                        if (DIR_VARIANT != 0 && arg1_reg <= `TCPI_POS_MAX)
                            POSITION_CODE <= arg1_reg;
                    `TCPI_VER_REQ:
                        if (arg1_reg == `TCPI_VER_ARG)
                            ver_pend_reg <= 1'b1;
                    default:
                        ver_pend_reg <= ver_pend_reg;
                endcase
            end
        end
    end

    // Faults and firmware location
    always @(posedge CLOCK)
    begin
        if (RST)
        begin
            SHORT_FAULT <= 1'b0;
            OPEN_FAULT <= 1'b0;
            prev_short_reg <= 1'b0;
            prev_open_reg <= 1'b0;
            FW_LOCATION <= 1'b0;
        end
        else
        begin
            SHORT_FAULT <= is_short;
            OPEN_FAULT <= is_open;
            prev_short_reg <= is_short;
            prev_open_reg <= is_open;
            if (REPROG_DONE)
                FW_LOCATION <= ~FW_LOCATION;
        end
    end

    wire set_cmd = cmd_apply && op_reg != `TCPI_VER_REQ && op_args(op_reg) != 2'd0;
    // Periodic tick and pending status; a new event during sending is kept
    always @(posedge CLOCK)
    begin
        if (RST || !SESSION_ACTIVE)
        begin
            tick_reg <= 32'd0;
            stat_pend_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= period_hit ? 32'd0 : tick_reg + 32'd1;
            if (period_hit || KNOB_EVENT || fault_edge || set_cmd)
                stat_pend_reg <= 1'b1;
            else if (tstate_reg == T_IDLE && !ver_pend_reg)
                stat_pend_reg <= 1'b0;
        end
    end

    // Sender
    always @*
    begin
        tx_len = (tstate_reg == T_VER) ? `TCPI_LEN_VER :
                 (DIR_VARIANT != 0) ? `TCPI_LEN_DIR : `TCPI_LEN_ST;
        tx_byte = `TCPI_SYNC;
        if (tstate_reg == T_VER)
        begin
            if (idx_reg == `TCPI_ONE4)
                tx_byte = `TCPI_VER_ID;
            else if (idx_reg != `TCPI_ZERO4)
                tx_byte = {FW_LOCATION, FW_VERSION};
        end
        else
        begin
            case (idx_reg)
                `TCPI_ONE4: tx_byte = `TCPI_ST_ID;
                `TCPI_IDX_CUR: tx_byte = cur_snap_reg;
                `TCPI_IDX_LF: tx_byte = `TCPI_ST_LF;
                `TCPI_IDX_FLO: tx_byte = frq_snap_reg[7:0];
                `TCPI_IDX_FHI: tx_byte = frq_snap_reg[15:8];
                `TCPI_IDX_ATT: tx_byte = att_snap_reg;
                `TCPI_IDX_DIRID: tx_byte = `TCPI_DIR_ID;
                `TCPI_IDX_POS: tx_byte = pos_snap_reg;
                default: tx_byte = `TCPI_SYNC;
            endcase
        end
    end

    always @(posedge CLOCK)
    begin
        if (RST || !SESSION_ACTIVE)
        begin
            tstate_reg <= T_IDLE;
            idx_reg <= `TCPI_ZERO4;
            cur_snap_reg <= `TCPI_ZERO8;
            frq_snap_reg <= `TCPI_ZERO16;
            att_snap_reg <= `TCPI_ZERO8;
            pos_snap_reg <= `TCPI_ZERO8;
        end
        else
        begin
            case (tstate_reg)
                T_IDLE:
                begin
                    idx_reg <= `TCPI_ZERO4;
                    // Version reply first; status snapshot frozen per packet
                    if (ver_pend_reg)
                        tstate_reg <= T_VER;
                    else if (stat_pend_reg)
                    begin
                        tstate_reg <= T_STAT;
                        cur_snap_reg <= CURRENT_MA;
                        frq_snap_reg <= TUNING_FREQUENCY_WORD;
                        att_snap_reg <= ATTENUATION_CODE;
                        pos_snap_reg <= POSITION_CODE;
                    end
                end
                T_STAT, T_VER:
                    if (tx_push)
                    begin
                        if (idx_reg == tx_len - `TCPI_ONE4)
                            tstate_reg <= T_IDLE;
                        idx_reg <= idx_reg + `TCPI_ONE4;
                    end
                default:
                    tstate_reg <= T_IDLE;
            endcase
        end
    end

    // Closing a session drops unsent bytes so no fragment leaks into the next
    tcpi_buf2 u_buf
    (
        .CLOCK(CLOCK),
        .RST(RST || !SESSION_ACTIVE),
        .in_data(tx_byte),
        .in_valid(tstate_reg != T_IDLE),
        .in_ready(buf_ready),
        .out_data(TX_DATA),
        .out_valid(TX_VALID),
        .out_ready(TX_READY)
    );
endmodule
`default_nettype wire

/* test/tcpi_chk.sv */
// Port-level assertions for the control packet interpreter
`default_nettype none
module tcpi_chk (
    input wire logic CLOCK, // clock
    input wire logic RST, // reset
    input wire logic CONN_REQ, // connect ask
    input wire logic CONN_ACCEPT, // accept
    input wire logic CONN_CLOSE, // close
    input wire logic SESSION_ACTIVE, // session
    input wire logic RX_READY, // rx ready
    input wire logic [7:0] TX_DATA, // tx byte
    input wire logic TX_VALID, // tx valid
    input wire logic TX_READY, // tx ready
    input wire logic [7:0] CURRENT_MA, // current
    input wire logic REPROG_DONE, // reprogrammed
    input wire logic [15:0] TUNING_FREQUENCY_WORD, // frequency
    input wire logic [7:0] POSITION_CODE, // direction
    input wire logic LOW_RANGE, // low range
    input wire logic FW_LOCATION, // fw location
    input wire logic SHORT_FAULT, // short
    input wire logic OPEN_FAULT // open
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    property p_accept; CONN_ACCEPT == (CONN_REQ && !SESSION_ACTIVE); endproperty
    a_accept: assert property (p_accept) else $error("accept wrong");
    property p_open; CONN_ACCEPT |=> SESSION_ACTIVE; endproperty
    a_open: assert property (p_open) else $error("session not shown");
    property p_hold; SESSION_ACTIVE && !CONN_CLOSE |=> SESSION_ACTIVE; endproperty
    a_hold: assert property (p_hold) else $error("session dropped");
    property p_rx; !SESSION_ACTIVE |-> !RX_READY; endproperty
    a_rx: assert property (p_rx) else $error("rx ready without session");
    // A stalled byte must not change or the packet is corrupted; a close drops it
    property p_tx;
        SESSION_ACTIVE && TX_VALID && !TX_READY && !CONN_CLOSE |=> TX_VALID && $stable(TX_DATA);
    endproperty
    a_tx: assert property (p_tx) else $error("tx byte not held");
    property p_short; (CURRENT_MA > 8'hC8) [*2] |-> SHORT_FAULT; endproperty
    a_short: assert property (p_short) else $error("short missed");
    property p_openf; (CURRENT_MA == 8'h00) [*2] |-> OPEN_FAULT && !SHORT_FAULT; endproperty
    a_openf: assert property (p_openf) else $error("open missed");
    property p_fw; REPROG_DONE |=> FW_LOCATION != $past(FW_LOCATION); endproperty
    a_fw: assert property (p_fw) else $error("location not flipped");
    property p_fwst; !REPROG_DONE |=> $stable(FW_LOCATION); endproperty
    a_fwst: assert property (p_fwst) else $error("location moved");
    property p_pos; POSITION_CODE <= 8'hE7; endproperty
    a_pos: assert property (p_pos) else $error("position out of range");
    property p_low; LOW_RANGE |-> TUNING_FREQUENCY_WORD == 16'h01F4; endproperty
    a_low: assert property (p_low) else $error("low range wrong");
endmodule
`default_nettype wire

/* test/tcpi_client.sv */
// Behavioural network client driving and draining the byte streams
`default_nettype none
module tcpi_client (
    input wire logic clock, // clock
    output logic [7:0] rx_data, // byte to device
    output logic rx_valid, // byte offered
    input wire logic rx_ready, // device takes
    output logic tx_ready // client takes
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] q[$];
    // Bench queues whole documented commands only
    function automatic void push(input logic [7:0] b);
        q.push_back(b);
    endfunction
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
    end
    always @(posedge clock)
    begin
        if (rx_valid && rx_ready)
            void'(q.pop_front());
        #1;
        tx_ready = ($urandom % 4) != 0;
        rx_valid = q.size() != 0;
        // Idle data toggles so nothing relies on a stale byte
        rx_data = rx_valid ? q[0] : ~rx_data;
    end
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the control packet interpreter
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] PER = 32'h0000_03E8;
    logic CLOCK = 1'b0, RST = 1'b1, CONN_REQ = 1'b0, CONN_CLOSE = 1'b0;
    logic KNOB_EVENT = 1'b0, REPROG_DONE = 1'b0, RX_VALID, RX_READY, TX_VALID, TX_READY;
    logic [7:0] CURRENT_MA = 8'h64, KNOB_ATT = 8'h00, RX_DATA, TX_DATA;
    logic [15:0] KNOB_TUNING_FREQUENCY_WORD = 16'h0000;
    logic [6:0] FW_VERSION = 7'h00;
    logic CONN_ACCEPT, SESSION_ACTIVE, LOW_RANGE, FW_LOCATION, SHORT_FAULT, OPEN_FAULT;
    logic [15:0] TUNING_FREQUENCY_WORD, f = 16'h0000;
    logic [7:0] ATTENUATION_CODE, POSITION_CODE, a = 8'h00, p = 8'h00;
    logic [87:0] exp_q[$];
    logic [87:0] pkt, last_pkt;
    logic [15:0] fv[4] = '{16'h01F3, 16'h01F4, 16'h7530, 16'h7531};
    logic loc = 1'b0;
    int nb = 0, n_per = 0, n_fail = 0, checked = 0, cyc = 0;
    tcpi_interp #(.DIR_VARIANT(1), .PERIOD_CYC(PER)) DUT (
        .CLOCK(CLOCK), .RST(RST), .CONN_REQ(CONN_REQ), .CONN_ACCEPT(CONN_ACCEPT),
        .CONN_CLOSE(CONN_CLOSE), .SESSION_ACTIVE(SESSION_ACTIVE), .RX_DATA(RX_DATA),
        .RX_VALID(RX_VALID), .RX_READY(RX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
        .TX_READY(TX_READY), .CURRENT_MA(CURRENT_MA), .KNOB_EVENT(KNOB_EVENT),
        .KNOB_TUNING_FREQUENCY_WORD(KNOB_TUNING_FREQUENCY_WORD), .KNOB_ATT(KNOB_ATT), .FW_VERSION(FW_VERSION),
        .REPROG_DONE(REPROG_DONE), .TUNING_FREQUENCY_WORD(TUNING_FREQUENCY_WORD),
        .ATTENUATION_CODE(ATTENUATION_CODE), .POSITION_CODE(POSITION_CODE),
        .LOW_RANGE(LOW_RANGE), .FW_LOCATION(FW_LOCATION), .SHORT_FAULT(SHORT_FAULT),
        .OPEN_FAULT(OPEN_FAULT));
    tcpi_client u_cli (.clock(CLOCK), .rx_data(RX_DATA), .rx_valid(RX_VALID),
        .rx_ready(RX_READY), .tx_ready(TX_READY));
    always #2 CLOCK = ~CLOCK;
    task automatic miss(input string what, input logic [87:0] e, input logic [87:0] g);
        $display("MISMATCH %s expected %h seen %h", what, e, g);
        n_fail++;
    endtask
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
            miss(what, 88'(e), 88'(g));
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [87:0] st_pkt();
        return {8'h0D, 8'h08, CURRENT_MA, 8'h0D, 8'h0A, f[7:0], f[15:8], a, 8'h0D, 8'h09, p};
    endfunction
    // Unmatched packets equal to the last status are the periodic ones
    task automatic take(input logic [87:0] got);
        checked++;
        if (exp_q.size() != 0 && got === exp_q[0])
        begin
            void'(exp_q.pop_front());
            if (got[79:72] === 8'h08)
                last_pkt = got;
        end
        else if (got === last_pkt)
            n_per++;
        else
            miss("packet", exp_q.size() != 0 ? exp_q[0] : last_pkt, got);
    endtask
    always @(posedge CLOCK)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            final_report();
        end
        // Bytes around a close belong to no packet
        if (CONN_CLOSE === 1'b1 || SESSION_ACTIVE !== 1'b1)
            nb = 0;
        else if (TX_VALID === 1'b1 && TX_READY === 1'b1)
        begin
            pkt = (nb == 0) ? {80'h0, TX_DATA} : {pkt[79:0], TX_DATA};
            nb++;
            if ((nb == 3 && pkt[15:8] === 8'hFF) || nb == 11)
            begin
                take(pkt);
                nb = 0;
            end
        end
    end
    task automatic settle();
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 600)
        begin
            @(posedge CLOCK);
            k++;
        end
        if (exp_q.size() != 0)
            miss("late packet", exp_q[0], 88'h0);
        exp_q.delete();
        @(posedge CLOCK);
        #1;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
        u_cli.push(8'h0D);
        u_cli.push(op);
        u_cli.push(arg[7:0]);
        if (op === 8'hB0)
            u_cli.push(arg[15:8]);
    endtask
    task automatic connect();
        CONN_REQ = 1'b1;
        #1;
        chk("accept", 16'h0001, {15'h0, CONN_ACCEPT});
        @(posedge CLOCK);
        #1;
        chk("accept again", 16'h0000, {15'h0, CONN_ACCEPT});
        chk("session", 16'h0001, {15'h0, SESSION_ACTIVE});
        CONN_REQ = 1'b0;
    endtask
    initial
    begin
        void'($urandom(13));
        FW_VERSION = 7'($urandom);
        last_pkt = st_pkt();
        repeat (3) @(posedge CLOCK);
        #1;
        RST = 1'b0;
        connect();
        $display("test connect done");
        for (int i = 0; i < 4; i++)
        begin
            a = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            cmd(8'hB4, {8'h00, a});
            exp_q.push_back(st_pkt());
            settle();
            chk("attenuation", {8'h00, a}, {8'h00, ATTENUATION_CODE});
        end
        $display("test attenuation done");
        for (int i = 0; i < 4; i++)
        begin
            f = fv[i];
            cmd(8'hB0, f);
            exp_q.push_back(st_pkt());
            settle();
            chk("frequency", f, TUNING_FREQUENCY_WORD);
            chk("low range", {15'h0, i == 1}, {15'h0, LOW_RANGE});
        end
        $display("test frequency done");
        p = 8'hE7;
        cmd(8'hB2, {8'h00, p});
        exp_q.push_back(st_pkt());
        settle();
        cmd(8'hB2, 16'h00E8);
        repeat (60) @(posedge CLOCK);
        #1;
        chk("position", 16'h00E7, {8'h00, POSITION_CODE});
        $display("test direction done");
        for (int i = 0; i < 2; i++)
        begin
            cmd(8'h12, 16'h0000);
            exp_q.push_back({64'h0, 8'h0D, 8'hFF, loc, FW_VERSION});
            settle();
            REPROG_DONE = 1'b1;
            loc = ~loc;
            @(posedge CLOCK);
            #1;
            REPROG_DONE = 1'b0;
            chk("location", {15'h0, loc}, {15'h0, FW_LOCATION});
        end
        $display("test version done");
        KNOB_TUNING_FREQUENCY_WORD = 16'($urandom % 30000);
        KNOB_ATT = 8'($urandom);
        KNOB_EVENT = 1'b1;
        f = KNOB_TUNING_FREQUENCY_WORD;
        a = KNOB_ATT;
        @(posedge CLOCK);
        #1;
        KNOB_EVENT = 1'b0;
        exp_q.push_back(st_pkt());
        settle();
        chk("knob frequency", f, TUNING_FREQUENCY_WORD);
        CURRENT_MA = 8'h00;
        exp_q.push_back(st_pkt());
        settle();
        chk("open", 16'h0001, {15'h0, OPEN_FAULT});
        CURRENT_MA = 8'hFA;
        exp_q.push_back(st_pkt());
        settle();
        chk("short", 16'h0001, {15'h0, SHORT_FAULT});
        $display("test local change done");
        n_per = 0;
        repeat (2600) @(posedge CLOCK);
        #1;
        chk("periodic", 16'h0001, {15'h0, n_per >= 2 && n_per <= 3});
        $display("test periodic done");
        CONN_CLOSE = 1'b1;
        @(posedge CLOCK);
        #1;
        CONN_CLOSE = 1'b0;
        chk("closed", 16'h0000, {15'h0, SESSION_ACTIVE});
        connect();
        // Two commands in one transmission: status after each, old attenuation first
        f = 16'h2710;
        cmd(8'hB0, f);
        exp_q.push_back(st_pkt());
        a = 8'h2A;
        cmd(8'hB4, {8'h00, a});
        exp_q.push_back(st_pkt());
        settle();
        chk("attenuation", {8'h00, a}, {8'h00, ATTENUATION_CODE});
        chk("frequency", f, TUNING_FREQUENCY_WORD);
        $display("test reconnect done");
        final_report();
    end
endmodule
bind tcpi_interp tcpi_chk u_chk (.CLOCK(CLOCK), .RST(RST), .CONN_REQ(CONN_REQ),
    .CONN_ACCEPT(CONN_ACCEPT), .CONN_CLOSE(CONN_CLOSE), .SESSION_ACTIVE(SESSION_ACTIVE),
    .RX_READY(RX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .CURRENT_MA(CURRENT_MA), .REPROG_DONE(REPROG_DONE), .POSITION_CODE(POSITION_CODE),
    .TUNING_FREQUENCY_WORD(TUNING_FREQUENCY_WORD), .LOW_RANGE(LOW_RANGE),
    .FW_LOCATION(FW_LOCATION), .SHORT_FAULT(SHORT_FAULT), .OPEN_FAULT(OPEN_FAULT));
`default_nettype wire
